//--- logic/fcsp_cfg.svh
// Purpose: Constants for the parallel flash command and status-poll controller.
// Assumes: Word-wide flash bus, 200 MHz ref_clk (5 ns period).
// Notes:   Strobe timings are plain defaults; adjust to the fitted part.
`ifndef FCSP_CFG_SVH
`define FCSP_CFG_SVH

// ==========================================================================
// Bus geometry
`define FCSP_ADDR_W 19
`define FCSP_DATA_W 16
`define FCSP_SECTOR_MASK 19'h7F000

// ==========================================================================
// Unlock and command codes (word mode)
`define FCSP_UNLOCK_A1 19'h00555
`define FCSP_UNLOCK_A2 19'h002AA
`define FCSP_QUERY_ADDR 19'h00055
`define FCSP_CODE_AA 16'h00AA
`define FCSP_CODE_55 16'h0055
`define FCSP_CODE_RESET 16'h00F0
`define FCSP_CODE_ID 16'h0090
`define FCSP_CODE_PROG 16'h00A0
`define FCSP_CODE_BYPASS 16'h0020
`define FCSP_CODE_ERASE 16'h0080
`define FCSP_CODE_CHIP 16'h0010
`define FCSP_CODE_SECTOR 16'h0030
`define FCSP_CODE_SUSPEND 16'h00B0
`define FCSP_CODE_RESUME 16'h0030
`define FCSP_CODE_QUERY 16'h0098
`define FCSP_CODE_EXIT2 16'h0000

// ==========================================================================
// Status bit positions
`define FCSP_BIT_POLL 7
`define FCSP_BIT_TOGGLE1 6
`define FCSP_BIT_TIMEOUT 5

// ==========================================================================
// Strobe timing
`define FCSP_CLK_NS 5
`define FCSP_T_STROBE_NS 70
`define FCSP_STROBE_CYC ((`FCSP_T_STROBE_NS + `FCSP_CLK_NS - 1) / `FCSP_CLK_NS)

`endif

//--- logic/fcsp_pkg.sv
// Purpose: Types shared by the flash controller modules.
// Assumes: fcsp_cfg.svh widths.
// Notes:   Command codes are the user-side opcodes.
`include "fcsp_cfg.svh"
package fcsp_pkg;

  typedef enum logic [3:0] {
    FCSP_CMD_READ = 4'h0,
    FCSP_CMD_RESET = 4'h1,
    FCSP_CMD_PROGRAM = 4'h2,
    FCSP_CMD_CHIP_ERASE = 4'h3,
    FCSP_CMD_SECTOR_ERASE = 4'h4,
    FCSP_CMD_ADD_SECTOR = 4'h5,
    FCSP_CMD_SUSPEND = 4'h6,
    FCSP_CMD_RESUME = 4'h7,
    FCSP_CMD_ID_READ = 4'h8,
    FCSP_CMD_QUERY = 4'h9,
    FCSP_CMD_BYPASS_ENTER = 4'hA,
    FCSP_CMD_BYPASS_PROG = 4'hB,
    FCSP_CMD_BYPASS_EXIT = 4'hC,
    FCSP_CMD_POLL = 4'hD
  } fcsp_cmd_type;

  typedef enum logic [1:0] {
    FCSP_STEP_END = 2'h0,
    FCSP_STEP_WRITE = 2'h1,
    FCSP_STEP_READ = 2'h2
  } fcsp_kind_type;

  typedef struct packed {
    fcsp_kind_type kind;
    logic [`FCSP_ADDR_W-1:0] addr;
    logic [`FCSP_DATA_W-1:0] data;
  } fcsp_step_type;

  // ==========================================================================
  // Command sequence table; upper lanes always zero on commands
  function automatic fcsp_step_type unlockStep(input logic [2:0] idx);
    fcsp_step_type s;
    s.kind = FCSP_STEP_WRITE;
    s.addr = idx[0] ? `FCSP_UNLOCK_A2 : `FCSP_UNLOCK_A1;
    s.data = idx[0] ? `FCSP_CODE_55 : `FCSP_CODE_AA;
    return s;
  endfunction : unlockStep

  function automatic fcsp_step_type wr(input logic [`FCSP_ADDR_W-1:0] a,
                                       input logic [`FCSP_DATA_W-1:0] d);
    fcsp_step_type s;
    s.kind = FCSP_STEP_WRITE;
    s.addr = a;
    s.data = d;
    return s;
  endfunction : wr

  function automatic fcsp_step_type seqStep(input fcsp_cmd_type c, input logic [2:0] i,
                                            input logic [`FCSP_ADDR_W-1:0] a,
                                            input logic [`FCSP_DATA_W-1:0] d);
    fcsp_step_type s;
    logic [`FCSP_ADDR_W-1:0] sa;
    s = '{kind: FCSP_STEP_END, addr: '0, data: '0};
    sa = a & `FCSP_SECTOR_MASK;
    case (c)
      FCSP_CMD_READ: if (i == 3'd0) s = '{kind: FCSP_STEP_READ, addr: a, data: '0};
      FCSP_CMD_RESET: if (i == 3'd0) s = wr('0, `FCSP_CODE_RESET);
      FCSP_CMD_PROGRAM: begin
        if (i < 3'd2) s = unlockStep(i);
        else if (i == 3'd2) s = wr(`FCSP_UNLOCK_A1, `FCSP_CODE_PROG);
        else if (i == 3'd3) s = wr(a, d);
      end
      FCSP_CMD_CHIP_ERASE, FCSP_CMD_SECTOR_ERASE: begin
        if (i == 3'd0 || i == 3'd1) s = unlockStep(i);
        else if (i == 3'd2) s = wr(`FCSP_UNLOCK_A1, `FCSP_CODE_ERASE);
        else if (i == 3'd3 || i == 3'd4) s = unlockStep(i - 3'd3);
        else if (i == 3'd5) begin
          s = (c == FCSP_CMD_CHIP_ERASE) ? wr(`FCSP_UNLOCK_A1, `FCSP_CODE_CHIP)
                                         : wr(sa, `FCSP_CODE_SECTOR);
        end
      end
      FCSP_CMD_ADD_SECTOR: if (i == 3'd0) s = wr(sa, `FCSP_CODE_SECTOR);
      FCSP_CMD_SUSPEND: if (i == 3'd0) s = wr('0, `FCSP_CODE_SUSPEND);
      FCSP_CMD_RESUME: if (i == 3'd0) s = wr('0, `FCSP_CODE_RESUME);
      FCSP_CMD_ID_READ: begin
        if (i < 3'd2) s = unlockStep(i);
        else if (i == 3'd2) s = wr(`FCSP_UNLOCK_A1, `FCSP_CODE_ID);
        else if (i == 3'd3) s = '{kind: FCSP_STEP_READ, addr: a, data: '0};
        else if (i == 3'd4) s = wr('0, `FCSP_CODE_RESET);
      end
      FCSP_CMD_QUERY: begin
        if (i == 3'd0) s = wr(`FCSP_QUERY_ADDR, `FCSP_CODE_QUERY);
        else if (i == 3'd1) s = '{kind: FCSP_STEP_READ, addr: a, data: '0};
        else if (i == 3'd2) s = wr('0, `FCSP_CODE_RESET);
      end
      FCSP_CMD_BYPASS_ENTER: begin
        if (i < 3'd2) s = unlockStep(i);
        else if (i == 3'd2) s = wr(`FCSP_UNLOCK_A1, `FCSP_CODE_BYPASS);
      end
      FCSP_CMD_BYPASS_PROG: begin
        if (i == 3'd0) s = wr('0, `FCSP_CODE_PROG);
        else if (i == 3'd1) s = wr(a, d);
      end
      FCSP_CMD_BYPASS_EXIT: begin
        if (i == 3'd0) s = wr('0, `FCSP_CODE_ID);
        else if (i == 3'd1) s = wr('0, `FCSP_CODE_EXIT2);
      end
      default: s = '{kind: FCSP_STEP_END, addr: '0, data: '0};
    endcase
    return s;
  endfunction : seqStep

endpackage : fcsp_pkg

//--- logic/fcsp_cyc_if.sv
// Purpose: One flash bus cycle request between sequencer and cycle engine.
// Assumes: Single clock domain.
// Notes:   req is held until done pulses.
`timescale 1ns/1ps
`include "fcsp_cfg.svh"
interface fcsp_cyc_if;
  logic req;
  logic isWrite;
  logic [`FCSP_ADDR_W-1:0] addr;
  logic [`FCSP_DATA_W-1:0] wdata;
  logic done;
  logic [`FCSP_DATA_W-1:0] rdata;

  modport master (output req, output isWrite, output addr, output wdata,
                  input done, input rdata);
  modport slave (input req, input isWrite, input addr, input wdata,
                 output done, output rdata);
endinterface : fcsp_cyc_if

//--- logic/fcsp_bus_cycle.sv
// Purpose: Runs one asynchronous flash read or write cycle on the pins.
// Assumes: Chip select framing the write or output strobe.
// Notes:   Write strobe falls after and rises before chip select.
`timescale 1ns/1ps
`include "fcsp_cfg.svh"
module fcsp_bus_cycle
  import fcsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  fcsp_cyc_if.slave cyc,
  output logic [`FCSP_ADDR_W-1:0] flashAddr,
  output logic [`FCSP_DATA_W-1:0] dqOut,
  output logic dqOe,
  input wire logic [`FCSP_DATA_W-1:0] dqIn,
  output logic ceN,
  output logic weN,
  output logic oeN
);

  typedef enum logic [3:0] {
    FCSP_E_IDLE = 4'b0001,
    FCSP_E_SETUP = 4'b0010,
    FCSP_E_STROBE = 4'b0100,
    FCSP_E_HOLD = 4'b1000
  } fcsp_eng_type;

  fcsp_eng_type state_r;
  logic [7:0] count_r;
  logic [`FCSP_DATA_W-1:0] rdata_r;

  // ==========================================================================
  // Cycle phases
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= FCSP_E_IDLE;
      count_r <= 8'h00;
    end else begin
      case (state_r)
        FCSP_E_IDLE: begin
          if (cyc.req) begin
            state_r <= FCSP_E_SETUP;
          end
        end
        FCSP_E_SETUP: begin
          state_r <= FCSP_E_STROBE;
          count_r <= 8'(`FCSP_STROBE_CYC - 1);
        end
        FCSP_E_STROBE: begin
          if (count_r == 8'h00) begin
            state_r <= FCSP_E_HOLD;
          end else begin
            count_r <= count_r - 8'h01;
          end
        end
        default: begin
          state_r <= FCSP_E_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pins: address held through the cycle, so either latching edge sees it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flashAddr <= '0;
      dqOut <= '0;
      dqOe <= 1'b0;
      ceN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
    end else begin
      if (state_r == FCSP_E_IDLE && cyc.req) begin
        flashAddr <= cyc.addr;
        dqOut <= cyc.wdata;
        dqOe <= cyc.isWrite;
        ceN <= 1'b0;
      end
      // Write strobe falls last and rises first, so it sets both edges
      if (state_r == FCSP_E_SETUP) begin
        weN <= ~cyc.isWrite;
        oeN <= cyc.isWrite;
      end
      if (state_r == FCSP_E_STROBE && count_r == 8'h00) begin
        weN <= 1'b1;
        oeN <= 1'b1;
      end
      if (state_r == FCSP_E_HOLD) begin
        ceN <= 1'b1;
        dqOe <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (state_r == FCSP_E_STROBE && count_r == 8'h00 && !cyc.isWrite) begin
      rdata_r <= dqIn;
    end
  end

  assign cyc.done = (state_r == FCSP_E_HOLD);
  assign cyc.rdata = rdata_r;

endmodule : fcsp_bus_cycle

//--- logic/flash_cmd_status_poll.sv
// Purpose: Host-side controller issuing flash command sequences and polling status.
// Assumes: Word-mode flash on plain pins; orders taken on a user port.
// Notes:
`timescale 1ns/1ps
`include "fcsp_cfg.svh"
module flash_cmd_status_poll
  import fcsp_pkg::*;
#(
  parameter int ADDR_W = `FCSP_ADDR_W,
  parameter int DATA_W = `FCSP_DATA_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [3:0] cmdCode,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdData,
  output logic rspDone,
  output logic [DATA_W-1:0] rspData,
  output logic rspFail,
  output logic rspRefused,
  output logic flashBusy,
  output logic bypassActive,
  output logic eraseActive,
  output logic suspendActive,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] dqOut,
  output logic dqOe,
  input wire logic [DATA_W-1:0] dqIn,
  output logic ceN,
  output logic weN,
  output logic oeN,
  input wire logic readyBusyN
);

  typedef enum logic [5:0] {
    FCSP_S_IDLE = 6'b000001,
    FCSP_S_ISSUE = 6'b000010,
    FCSP_S_WAIT = 6'b000100,
    FCSP_S_POLLA = 6'b001000,
    FCSP_S_POLLB = 6'b010000,
    FCSP_S_FINAL = 6'b100000
  } fcsp_state_type;

  fcsp_state_type state_r;
  fcsp_cmd_type cmd_r;
  logic [ADDR_W-1:0] opAddr_r;
  logic [DATA_W-1:0] opData_r;
  logic [2:0] stepIdx_r;
  logic [DATA_W-1:0] firstRead_r;
  logic recheck_r;
  logic failing_r;
  logic window_r;
  logic needPoll_r;
  logic busy_r;
  fcsp_step_type step;
  logic refuse;
  logic toggling;
  logic cycReq;

  fcsp_cyc_if cyc ();

  assign step = seqStep(cmd_r, stepIdx_r, opAddr_r, opData_r);

  // ==========================================================================
  // Acceptance of orders against the tracked flash mode
  always_comb begin
    refuse = 1'b0;
    case (fcsp_cmd_type'(cmdCode))
      FCSP_CMD_BYPASS_PROG: refuse = !bypassActive;
      FCSP_CMD_SUSPEND: refuse = !eraseActive || suspendActive;
      FCSP_CMD_RESUME: refuse = !suspendActive;
      FCSP_CMD_QUERY: refuse = bypassActive || (eraseActive && !suspendActive);
      FCSP_CMD_ADD_SECTOR: refuse = !window_r;
      FCSP_CMD_READ, FCSP_CMD_RESET, FCSP_CMD_POLL, FCSP_CMD_BYPASS_EXIT: refuse = 1'b0;
      FCSP_CMD_PROGRAM, FCSP_CMD_ID_READ: refuse = bypassActive || (eraseActive && !suspendActive);
      default: refuse = bypassActive || eraseActive;
    endcase
    if (cmdCode > 4'hD) begin
      refuse = 1'b1;
    end
  end

  // Toggling judged on two back-to-back reads at the operation address
  assign toggling = firstRead_r[`FCSP_BIT_TOGGLE1] != cyc.rdata[`FCSP_BIT_TOGGLE1];
  assign cmdReady = (state_r == FCSP_S_IDLE);

  // ==========================================================================
  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= FCSP_S_IDLE;
      cmd_r <= FCSP_CMD_READ;
      opAddr_r <= '0;
      opData_r <= '0;
      stepIdx_r <= 3'd0;
      firstRead_r <= '0;
      recheck_r <= 1'b0;
      failing_r <= 1'b0;
      needPoll_r <= 1'b0;
    end else begin
      case (state_r)
        FCSP_S_IDLE: begin
          if (cmdValid && !refuse) begin
            state_r <= FCSP_S_ISSUE;
            cmd_r <= fcsp_cmd_type'(cmdCode);
            opAddr_r <= cmdAddr;
            opData_r <= cmdData;
            stepIdx_r <= 3'd0;
            recheck_r <= 1'b0;
            failing_r <= 1'b0;
            needPoll_r <= cmdCode == FCSP_CMD_PROGRAM || cmdCode == FCSP_CMD_BYPASS_PROG
                          || cmdCode == FCSP_CMD_SUSPEND || cmdCode == FCSP_CMD_POLL;
          end
        end
        FCSP_S_ISSUE: begin
          if (step.kind == FCSP_STEP_END) begin
            // Status only trusted after the final write strobe has risen
            state_r <= needPoll_r ? FCSP_S_POLLA : FCSP_S_IDLE;
          end else begin
            state_r <= FCSP_S_WAIT;
          end
        end
        FCSP_S_WAIT: begin
          if (cyc.done) begin
            stepIdx_r <= stepIdx_r + 3'd1;
            state_r <= FCSP_S_ISSUE;
          end
        end
        FCSP_S_POLLA: begin
          if (cyc.done) begin
            firstRead_r <= cyc.rdata;
            state_r <= FCSP_S_POLLB;
          end
        end
        FCSP_S_POLLB: begin
          if (cyc.done) begin
            if (!toggling) begin
              state_r <= FCSP_S_FINAL;
            end else if (cyc.rdata[`FCSP_BIT_TIMEOUT] && recheck_r) begin
              // Still toggling after the flag rose: failed, send reset
              failing_r <= 1'b1;
              needPoll_r <= 1'b0;
              cmd_r <= FCSP_CMD_RESET;
              stepIdx_r <= 3'd0;
              state_r <= FCSP_S_ISSUE;
            end else begin
              // Toggle may stop just as the flag rises, so look once more
              recheck_r <= cyc.rdata[`FCSP_BIT_TIMEOUT];
              state_r <= FCSP_S_POLLA;
            end
          end
        end
        FCSP_S_FINAL: begin
          if (cyc.done) begin
            state_r <= FCSP_S_IDLE;
          end
        end
        default: state_r <= FCSP_S_IDLE;
      endcase
    end
  end

  // Status reads go to the operation address, never an arbitrary one
  assign cycReq = (state_r == FCSP_S_ISSUE && step.kind != FCSP_STEP_END) ||
                  (state_r == FCSP_S_WAIT && !cyc.done) ||
                  state_r == FCSP_S_POLLA || state_r == FCSP_S_POLLB ||
                  state_r == FCSP_S_FINAL;
  assign cyc.req = cycReq && !cyc.done;
  assign cyc.isWrite = (state_r == FCSP_S_ISSUE || state_r == FCSP_S_WAIT) &&
                       step.kind == FCSP_STEP_WRITE;
  assign cyc.addr = (state_r == FCSP_S_ISSUE || state_r == FCSP_S_WAIT) ? step.addr
                    : opAddr_r;
  assign cyc.wdata = step.data;

  // ==========================================================================
  // Answer to the user
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rspDone <= 1'b0;
      rspData <= '0;
      rspFail <= 1'b0;
      rspRefused <= 1'b0;
    end else begin
      rspDone <= 1'b0;
      if (state_r == FCSP_S_IDLE && cmdValid && refuse) begin
        rspDone <= 1'b1;
        rspRefused <= 1'b1;
        rspFail <= 1'b0;
      end else if ((state_r == FCSP_S_ISSUE && step.kind == FCSP_STEP_END && !needPoll_r) ||
                   (state_r == FCSP_S_FINAL && cyc.done)) begin
        rspDone <= 1'b1;
        rspRefused <= 1'b0;
        rspFail <= failing_r;
      end
      if ((state_r == FCSP_S_WAIT && step.kind == FCSP_STEP_READ) || state_r == FCSP_S_FINAL) begin
        if (cyc.done) begin
          rspData <= cyc.rdata;
        end
      end
    end
  end

  // ==========================================================================
  // Tracked flash mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bypassActive <= 1'b0;
      eraseActive <= 1'b0;
      suspendActive <= 1'b0;
      window_r <= 1'b0;
    end else if (state_r == FCSP_S_IDLE && cmdValid && !refuse) begin
      window_r <= cmdCode == FCSP_CMD_SECTOR_ERASE || cmdCode == FCSP_CMD_ADD_SECTOR;
      case (fcsp_cmd_type'(cmdCode))
        FCSP_CMD_BYPASS_ENTER: bypassActive <= 1'b1;
        FCSP_CMD_BYPASS_EXIT, FCSP_CMD_RESET: bypassActive <= 1'b0;
        FCSP_CMD_SECTOR_ERASE, FCSP_CMD_CHIP_ERASE: eraseActive <= 1'b1;
        FCSP_CMD_SUSPEND: suspendActive <= 1'b1;
        FCSP_CMD_RESUME: suspendActive <= 1'b0;
        default: bypassActive <= bypassActive;
      endcase
    end else if (state_r == FCSP_S_FINAL && cyc.done && cmd_r == FCSP_CMD_POLL) begin
      eraseActive <= eraseActive && suspendActive;
    end else if (failing_r && state_r == FCSP_S_ISSUE && step.kind == FCSP_STEP_END) begin
      eraseActive <= 1'b0;
      suspendActive <= 1'b0;
    end
  end

  // Open-drain ready/busy pin, pulled up, low while the flash works
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= ~readyBusyN;
    end
  end
  assign flashBusy = busy_r;

  fcsp_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .reset(reset),
    .cyc(cyc.slave),
    .flashAddr(flashAddr),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .dqIn(dqIn),
    .ceN(ceN),
    .weN(weN),
    .oeN(oeN)
  );

endmodule : flash_cmd_status_poll

//--- tb/fcsp_chk.sv
// Purpose: Port assertions for the flash controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Strobe width of 14 cycles follows the chosen 70 ns default.
`timescale 1ns/1ps
module fcsp_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [3:0] cmdCode,
  input wire logic rspDone,
  input wire logic rspRefused,
  input wire logic flashBusy,
  input wire logic bypassActive,
  input wire logic eraseActive,
  input wire logic suspendActive,
  input wire logic [18:0] flashAddr,
  input wire logic [15:0] dqOut,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic readyBusyN
);
  // ==========
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic take;
  assign take = cmdValid && cmdReady;
  strobe_excl_a: assert property (weN || oeN)
    else $error("both strobes low");
  wr_width_a: assert property ($fell(weN) |-> (!weN)[*8] ##1 (!weN)[*6] ##1 weN)
    else $error("write strobe width");
  rd_width_a: assert property ($fell(oeN) |-> (!oeN)[*8] ##1 (!oeN)[*6] ##1 oeN)
    else $error("read strobe width");
  wr_frame_a: assert property ($fell(weN) |-> !ceN && dqOe && $stable(flashAddr))
    else $error("write not framed");
  wr_hold_a: assert property (!weN && !$past(weN) |-> $stable(dqOut))
    else $error("data moved in strobe");
  ce_release_a: assert property ($rose(ceN) |-> weN && oeN && !dqOe)
    else $error("select released early");
  byp_refuse_a: assert property (take && cmdCode == 4'hB && !bypassActive
    |=> rspDone && rspRefused && ceN) else $error("bypass program taken");
  sus_refuse_a: assert property (take && cmdCode == 4'h6 && !eraseActive
    |=> rspDone && rspRefused && ceN) else $error("suspend taken");
  res_refuse_a: assert property (take && cmdCode == 4'h7 && !suspendActive
    |=> rspDone && rspRefused && ceN) else $error("resume taken");
  qry_refuse_a: assert property (take && cmdCode == 4'h9 && bypassActive
    |=> rspDone && rspRefused) else $error("query taken in bypass");
  busy_track_a: assert property ($fell(readyBusyN) |=> flashBusy)
    else $error("busy not tracked");
  cover property (take && cmdCode == 4'h2);
  cover property (rspDone && rspRefused);
  cover property ($fell(readyBusyN));
endmodule : fcsp_chk
bind flash_cmd_status_poll fcsp_chk u_chk (.ref_clk, .reset, .cmdValid, .cmdReady, .cmdCode,
  .rspDone, .rspRefused, .flashBusy, .bypassActive, .eraseActive, .suspendActive,
  .flashAddr, .dqOut, .dqOe, .ceN, .weN, .oeN, .readyBusyN);

//--- tb/fcsp_flash_model.sv
// Purpose: Behavioural flash device answering the controller's bus cycles.
// Assumes: Word mode; busy lasts a fixed number of status reads.
// Notes: Suspend stops busy, resume restarts it; failMode keeps toggling with the timeout bit.
`timescale 1ns/1ps
module fcsp_flash_model #(
  parameter logic [15:0] DEV_ID = 16'hA5C3, // Arbitrary value
  parameter int BUSY_READS = 6
) (
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic [18:0] flashAddr,
  input wire logic [15:0] dqOut,
  output logic [15:0] dqIn,
  output logic readyBusyN,
  input wire logic failMode
);
  // ==========
  // Command decode
  logic [18:0] addrLat = '0;
  logic [18:0] progAddr = '0;
  logic [15:0] memData = 16'h5A3C;
  logic [15:0] lastOut = 16'h0000;
  logic [1:0] st = 2'd0;
  logic tog = 1'b0, idMode = 1'b0, bypass = 1'b0, ersArm = 1'b0, eraseWin = 1'b0;
  int busyLeft = 0;
  always @(negedge weN or negedge ceN) if (!weN && !ceN) addrLat = flashAddr;
  always @(posedge weN) if (!ceN) wr(addrLat, dqOut);
  // Only the low byte and low address bits decode, so upper lanes are ignored
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    if (d[7:0] == 8'hF0) begin
      st = 2'd0;
      idMode = 1'b0;
      bypass = 1'b0;
      busyLeft = 0;
    end else if (st == 2'd3) begin
      memData = d;
      progAddr = a;
      busyLeft = BUSY_READS;
      st = 2'd0;
    end else if (bypass) begin
      if (d[7:0] == 8'hA0) st = 2'd3;
      if (d[7:0] == 8'h00) bypass = 1'b0;
    end else if (d[7:0] == 8'hB0) begin
      busyLeft = 0;
    end else if (eraseWin && d[7:0] == 8'h30) begin
      busyLeft = BUSY_READS;
    end else if (st == 2'd2) begin
      st = 2'd0;
      if (ersArm && (d[7:0] == 8'h30 || d[7:0] == 8'h10)) begin
        eraseWin = 1'b1;
        busyLeft = BUSY_READS;
      end else if (a[10:0] == 11'h555) begin
        st = (d[7:0] == 8'hA0) ? 2'd3 : 2'd0;
        idMode = d[7:0] == 8'h90;
        bypass = d[7:0] == 8'h20;
      end
      ersArm = !ersArm && a[10:0] == 11'h555 && d[7:0] == 8'h80;
    end else begin
      st = (st == 2'd0 && a[10:0] == 11'h555 && d[7:0] == 8'hAA) ? 2'd1 :
           (st == 2'd1 && a[10:0] == 11'h2AA && d[7:0] == 8'h55) ? 2'd2 : 2'd0;
    end
  endtask : wr
  always @(negedge oeN) begin
    if (!ceN && busyLeft > 0) begin
      tog = ~tog;
      lastOut = {8'h00, eraseWin ? 1'b0 : ~memData[7], tog, failMode, 1'b0, eraseWin,
                 eraseWin & tog, 2'b00};
      if (!failMode) busyLeft--;
      if (busyLeft == 0) eraseWin = 1'b0;
    end else if (!ceN && idMode) begin
      lastOut = (flashAddr[7:0] == 8'h01) ? DEV_ID : 16'h0000;
    end else if (!ceN) begin
      lastOut = memData;
    end
  end
  // A released bus shows the inverse so a stale value cannot pass
  assign dqIn = (!ceN && !oeN) ? lastOut : ~lastOut;
  assign readyBusyN = (busyLeft == 0);
endmodule : fcsp_flash_model

//--- tb/flash_cmd_status_poll_tb.sv
// Purpose: Self-checking bench for the flash command and poll controller.
// Assumes: Behavioural flash model on the pins.
// Notes: Suspend and resume are checked as refusals and within one sector erase.
`timescale 1ns/1ps
module flash_cmd_status_poll_tb;
  // ==========
  // Bench
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  logic [3:0] cmdCode = 4'h0;
  logic [18:0] cmdAddr = '0;
  logic [15:0] cmdData = '0;
  logic failMode = 1'b0;
  logic cmdReady, rspDone, rspFail, rspRefused, flashBusy, bypassActive, eraseActive;
  logic suspendActive, dqOe, ceN, weN, oeN, readyBusyN, sawBusy;
  logic [15:0] rspData, dqOut, dqIn;
  logic [18:0] flashAddr;
  int miscompares = 0;
  int total_checks = 0;
  int nWr = 0;
  int nRd = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge weN) if (!ceN) nWr++;
  always @(negedge oeN) if (!ceN) nRd++;
  always @(posedge ref_clk) if (flashBusy === 1'b1) sawBusy = 1'b1;
  flash_cmd_status_poll DUT (.ref_clk, .reset, .cmdValid, .cmdReady, .cmdCode, .cmdAddr,
    .cmdData, .rspDone, .rspData, .rspFail, .rspRefused, .flashBusy, .bypassActive,
    .eraseActive, .suspendActive, .flashAddr, .dqOut, .dqOe, .dqIn, .ceN, .weN, .oeN,
    .readyBusyN);
  fcsp_flash_model flash (.ceN, .weN, .oeN, .flashAddr, .dqOut, .dqIn, .readyBusyN, .failMode);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic issue(input logic [3:0] code, input logic [18:0] a, input logic [15:0] d);
    logic rdy;
    int n;
    nWr = 0;
    nRd = 0;
    sawBusy = 1'b0;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdAddr <= a;
    cmdData <= d;
    do begin
      @(negedge ref_clk);
      rdy = cmdReady;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rspDone !== 1'b1 && n < 5000);
    if (n >= 5000) check("completion", 0, 1);
  endtask : issue
  task automatic t_basic;
    issue(4'h0, 19'h00123, 16'h0000);
    check("read data", rspData, 16'h5A3C);
    check("read strobes", {nWr[15:0], nRd[15:0]}, 32'h0000_0001);
    issue(4'h2, 19'h4A5A5, 16'hC35A);
    check("program data", rspData, 16'hC35A);
    check("program fail", rspFail, 0);
    check("program writes", nWr, 4);
    check("program address", flash.progAddr, 19'h4A5A5);
    check("busy seen", sawBusy, 1);
    issue(4'h8, 19'h00001, 16'h0000);
    check("id data", rspData, 16'hA5C3);
    check("id cycles", {nWr[15:0], nRd[15:0]}, 32'h0004_0001);
    check("id left", flash.idMode, 0);
    issue(4'h9, 19'h00010, 16'h0000);
    check("query cycles", {nWr[15:0], nRd[15:0]}, 32'h0002_0001);
    issue(4'h1, 19'h00000, 16'h0000);
    check("reset writes", nWr, 1);
  endtask : t_basic
  task automatic t_refuse;
    logic [3:0] codes [5] = '{4'hB, 4'h6, 4'h7, 4'hE, 4'hF};
    foreach (codes[i]) begin
      issue(codes[i], 19'h00000, 16'h0000);
      check("refused", rspRefused, 1);
      check("refused pins", nWr + nRd, 0);
    end
  endtask : t_refuse
  task automatic t_bypass;
    issue(4'hA, 19'h00000, 16'h0000);
    check("bypass on", bypassActive, 1);
    issue(4'h9, 19'h00000, 16'h0000);
    check("query in bypass", rspRefused, 1);
    issue(4'hB, 19'h01234, 16'h0F0F);
    check("bypass data", rspData, 16'h0F0F);
    check("bypass writes", nWr, 2);
    issue(4'hC, 19'h00000, 16'h0000);
    check("bypass off", {bypassActive, flash.bypass}, 0);
  endtask : t_bypass
  task automatic t_erase;
    issue(4'h4, 19'h23000, 16'h0000);
    check("erase writes", nWr, 6);
    check("erase flag", eraseActive, 1);
    issue(4'h5, 19'h24000, 16'h0000);
    check("add writes", nWr, 1);
    issue(4'h0, 19'h23000, 16'h0000);
    check("erase status", {rspData[7], rspData[3]}, 1);
    issue(4'h6, 19'h23000, 16'h0000);
    check("suspended", suspendActive, 1);
    check("toggle stops", flash.busyLeft, 0);
    issue(4'h7, 19'h23000, 16'h0000);
    check("resumed", {suspendActive, eraseActive}, 1);
    issue(4'hD, 19'h23000, 16'h0000);
    check("erase end", {rspFail, eraseActive, flash.eraseWin}, 0);
    @(posedge ref_clk);
    failMode <= 1'b1;
    issue(4'h2, 19'h00010, 16'h1111);
    check("timeout fail", rspFail, 1);
    check("reset sent", flash.busyLeft, 0);
    @(posedge ref_clk);
    failMode <= 1'b0;
    issue(4'h3, 19'h00000, 16'h0000);
    check("chip erase", {nWr[3:0], eraseActive}, 5'h0D);
    issue(4'hD, 19'h00000, 16'h0000);
    check("chip done", {eraseActive, flash.eraseWin}, 0);
  endtask : t_erase
  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_basic;
    t_refuse;
    t_bypass;
    t_erase;
    close_out;
  end
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule : flash_cmd_status_poll_tb
